// file: test/nvsc_dev.sv
module nvsc_dev (
  input  wire logic        pwr_i,
  input  wire logic [12:0] a_i,
  input  wire logic        cs_n_i,
  input  wire logic        oe_n_i,
  input  wire logic        we_n_i,
  input  wire logic [7:0]  d_i,
  output wire logic [7:0]  d_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0]  ram [8192], nv [8192], q = 8'h00;
  logic [12:0] sl [5] = '{13'h0, 13'h1555, 13'h0aaa, 13'h1fff, 13'h10f0};
  logic        bsy = 0, dty = 0, rd = 0;
  int          stp = 0;
  wire drv = !cs_n_i && !oe_n_i && we_n_i && !bsy;
  wire wr = !cs_n_i && !we_n_i;
  // read data follows address; released lines show the inverse
  always @* if (drv) q = ram[a_i];
  assign d_o = drv ? q : ~q;
  // write lands at end of access and breaks any sequence
  always @(negedge wr) begin
    if (pwr_i && !bsy) {ram[a_i], dty} = {d_i, 1'b1};
    stp = 0;
  end
  // select-timed reads step the sequence, sixth one saves or restores
  always @(negedge cs_n_i) #1 rd = we_n_i;
  always @(posedge cs_n_i) if (rd && !bsy) begin
    if (stp == 5 && (a_i | 13'h1) == 13'h0f0f) begin
      bsy = 1;
      if (a_i[0] && pwr_i) nv = ram;
      if (!a_i[0]) ram = nv;
      #1500 {bsy, dty, stp} = 0;
    end else stp = stp < 5 && a_i == sl[stp] ? stp + 1 : a_i == 0;
  end
  // supply loss saves written data, return restores it
  always @(negedge pwr_i) if (dty) nv = ram;
  always @(posedge pwr_i) begin
    ram = nv;
    dty = 0;
  end
endmodule

// file: test/nvsc_host_tb.sv
module nvsc_host_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int CYC = 20;
  logic        clk_i = 0, arst_n_i = 0, req_valid_i = 0, pwr_ok_i = 1;
  logic        req_ready_o, rsp_valid_o, busy_o, mem_csel_n_o, mem_oen_n_o;
  logic        mem_wstb_n_o, mem_data_oe_o;
  logic [1:0]  req_cmd_i = 0;
  logic [12:0] req_addr_i = 0, mem_addr_o, ad [8];
  logic [7:0]  req_wdata_i = 0, mem_data_o, rsp_rdata_o, dq, old, img [8192];
  int          miscompares = 0, n_checks = 0, seed = 32'hb167;
  wire  [7:0]  mem_data_i = mem_data_oe_o ? mem_data_o : dq;
  logic        ce_i = 1;
  nvsc_host #(.SAVE_CYC(CYC), .RESTORE_CYC(CYC), .PWRUP_CYC(CYC))
    u_nvsc_host (.clk_i(clk_i), .arst_n_i(arst_n_i), .ce_i(ce_i),
    .req_valid_i(req_valid_i), .req_cmd_i(req_cmd_i),
    .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i),
    .pwr_ok_i(pwr_ok_i), .req_ready_o(req_ready_o),
    .rsp_valid_o(rsp_valid_o), .rsp_rdata_o(rsp_rdata_o),
    .busy_o(busy_o), .mem_addr_o(mem_addr_o),
    .mem_csel_n_o(mem_csel_n_o), .mem_oen_n_o(mem_oen_n_o),
    .mem_wstb_n_o(mem_wstb_n_o), .mem_data_i(mem_data_i),
    .mem_data_o(mem_data_o), .mem_data_oe_o(mem_data_oe_o));
  nvsc_dev u_nvsc_dev (.pwr_i(pwr_ok_i), .a_i(mem_addr_o),
    .cs_n_i(mem_csel_n_o), .oe_n_i(mem_oen_n_o), .we_n_i(mem_wstb_n_o),
    .d_i(mem_data_i), .d_o(dq));
  always #50 clk_i = ~clk_i;
  task automatic chk(input string nm, input logic [7:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // one request held until taken, then wait for the answer
  task automatic go(input logic [1:0] c, input logic [12:0] a,
                    input logic [7:0] w);
    int n;
    n = 0;
    {req_valid_i, req_cmd_i, req_addr_i, req_wdata_i} <= {1'b1, c, a, w};
    do @(posedge clk_i); while (req_ready_o !== 1'b1 && ++n < 300);
    req_valid_i <= 0;
    do @(posedge clk_i); while (rsp_valid_o !== 1'b1 && ++n < 300);
    chk("answer", {7'h0, n < 300}, 8'h01);
  endtask
  task automatic close_out;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // random writes with corner addresses, read back, save, power loss
  initial begin
    repeat (8) @(posedge clk_i);
    arst_n_i <= 1;
    repeat (CYC + 4) @(posedge clk_i);
    chk("busy", {7'h0, busy_o}, 8'h00);
    foreach (ad[i]) begin
      ad[i] = i < 2 ? {13{i[0]}} : 13'($random(seed));
      img[ad[i]] = 8'($random(seed));
      go(1, ad[i], img[ad[i]]);
    end
    foreach (ad[i]) begin
      go(0, ad[i], 8'h00);
      chk("read", rsp_rdata_o, img[ad[i]]);
    end
    $display("test rw done");
    // clock enable low: a pending read must not start
    ce_i <= 0;
    {req_valid_i, req_cmd_i, req_addr_i} <= {1'b1, 2'h0, ad[0]};
    repeat (8) @(posedge clk_i);
    chk("frozen", {7'h0, mem_csel_n_o}, 8'h01);
    req_valid_i <= 0;
    ce_i <= 1;
    @(posedge clk_i);
    $display("test freeze done");
    go(2, 13'h0, 8'h00);
    old = img[ad[3]];
    go(1, ad[3], ~old);
    go(3, 13'h0, 8'h00);
    go(0, ad[3], 8'h00);
    chk("restore", rsp_rdata_o, old);
    $display("test save done");
    img[ad[4]] = ~img[ad[4]];
    go(1, ad[4], img[ad[4]]);
    pwr_ok_i <= 0;
    repeat (3) @(posedge clk_i);
    chk("ready", {7'h0, req_ready_o}, 8'h00);
    pwr_ok_i <= 1;
    repeat (CYC + 4) @(posedge clk_i);
    go(0, ad[4], 8'h00);
    chk("autosave", rsp_rdata_o, img[ad[4]]);
    $display("test power done");
    close_out;
  end
  // hang guard
  initial begin
    #400000;
    miscompares++;
    close_out;
  end
endmodule
bind nvsc_host nvsc_sva u_nvsc_sva (.clk_i(clk_i), .arst_n_i(arst_n_i),
  .busy_o(busy_o), .mem_addr_o(mem_addr_o), .mem_csel_n_o(mem_csel_n_o),
  .mem_oen_n_o(mem_oen_n_o), .mem_wstb_n_o(mem_wstb_n_o),
  .mem_data_oe_o(mem_data_oe_o));

// file: test/nvsc_sva.sv
module nvsc_sva (
  input wire logic        clk_i,
  input wire logic        arst_n_i,
  input wire logic        busy_o,
  input wire logic [12:0] mem_addr_o,
  input wire logic        mem_csel_n_o,
  input wire logic        mem_oen_n_o,
  input wire logic        mem_wstb_n_o,
  input wire logic        mem_data_oe_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  // write phase; sequence step has enable high and host not driving
  wire wr = !mem_csel_n_o && !mem_wstb_n_o;
  wire sq = mem_oen_n_o && !mem_data_oe_o;
  property p_hold; wr |=> $stable(mem_addr_o); endproperty
  a_hold: assert property (p_hold) else $error("addr moved");
  property p_oen; wr |-> mem_oen_n_o && mem_data_oe_o; endproperty
  a_oen: assert property (p_oen) else $error("oen in write");
  property p_csel; $fell(mem_csel_n_o) |=> !mem_csel_n_o ##1 mem_csel_n_o;
  endproperty
  a_csel: assert property (p_csel) else $error("select width");
  property p_busy; busy_o && $past(busy_o, 4) |-> mem_wstb_n_o; endproperty
  a_busy: assert property (p_busy) else $error("write in busy");
  property p_seq1; $fell(mem_csel_n_o) && sq && mem_addr_o == 13'h0000
    |-> ##[3:9] !mem_csel_n_o && sq && mem_addr_o == 13'h1555; endproperty
  a_seq1: assert property (p_seq1) else $error("step two");
  property p_seq6; $fell(mem_csel_n_o) && sq && mem_addr_o == 13'h10f0
    |-> ##[3:9] sq && (mem_addr_o | 13'h0001) == 13'h0f0f; endproperty
  a_seq6: assert property (p_seq6) else $error("step six");
  c_wr: cover property (wr);
  c_seq: cover property (sq && mem_addr_o == 13'h10f0);
  c_busy: cover property ($fell(busy_o));
endmodule

// file: verilog/nvsc_defs.vh
`ifndef NVSC_DEFS_VH
`define NVSC_DEFS_VH
// clock period in ns (10 MHz)
`define NVSC_CLK_NS        100
// sequence addresses
`define NVSC_SEQ_A0        13'h0000
`define NVSC_SEQ_A1        13'h1555
`define NVSC_SEQ_A2        13'h0aaa
`define NVSC_SEQ_A3        13'h1fff
`define NVSC_SEQ_A4        13'h10f0
`define NVSC_SEQ_SAVE      13'h0f0f
`define NVSC_SEQ_RESTORE   13'h0f0e
// durations in their own units
`define NVSC_SAVE_MS       10
`define NVSC_RESTORE_US    20
`define NVSC_PWRUP_US      550
// cycle counts derived from the durations
`define NVSC_SAVE_CYC      ((`NVSC_SAVE_MS * 1000000) / `NVSC_CLK_NS)
`define NVSC_RESTORE_CYC   ((`NVSC_RESTORE_US * 1000) / `NVSC_CLK_NS)
`define NVSC_PWRUP_CYC     ((`NVSC_PWRUP_US * 1000) / `NVSC_CLK_NS)
// access phase lengths in cycles (each at least one 100 ns cycle)
`define NVSC_SETUP_CYC     1
`define NVSC_STROBE_CYC    2
`define NVSC_HOLD_CYC      1
// command codes
`define NVSC_CMD_READ      2'h0
`define NVSC_CMD_WRITE     2'h1
`define NVSC_CMD_SAVE      2'h2
`define NVSC_CMD_RESTORE   2'h3
`endif

// file: verilog/nvsc_host.v
`include "nvsc_defs.vh"

// Functional notes
// [RQ1] read happens while chip select low, output enable low, strobe high
// [RQ2] thirteen address bits select one of 8,192 bytes
// [RQ3] read data follows address while selected, valid until control change
// [RQ4] write happens while chip select and strobe low, latched at end
// [RQ5] host holds address stable across entire write access
// [RQ6] host keeps output enable high throughout write access
// [RQ7] device turns off its drivers after strobe falls if enable low
// [RQ8] supply loss starts automatic save within 500ns
// [RQ9] automatic save skipped when no write since last save or restore
// [RQ10] software save always executes
// [RQ11] power-up or low supply latches restore, started above switch threshold
// [RQ12] host must not hold write state when power-up restore ends
// [RQ13] save starts after reads 0000,1555,0AAA,1FFF,10F0,0F0F in order
// [RQ14] restore starts after reads 0000,1555,0AAA,1FFF,10F0,0F0E in order
// [RQ15] any other access aborts the sequence, no save or restore
// [RQ16] sequence steps are chip-select timed reads, strobe high
// [RQ17] save erases then programs nonvolatile copy of RAM
// [RQ18] after save starts, device disables all input and output
// [RQ19] after software save, access resumes within 10 ms
// [RQ20] restore clears RAM, copies nonvolatile data, resumes within 20 us
// [RQ21] below switch threshold, software saves and writes are blocked
// [RQ22] sequence detector restarts at first step after completion or abort
module nvsc_host #(
  parameter SAVE_CYC    = `NVSC_SAVE_CYC,
  parameter RESTORE_CYC = `NVSC_RESTORE_CYC,
  parameter PWRUP_CYC   = `NVSC_PWRUP_CYC
) (
  // clock, reset and clock enable
  input  wire        clk_i,
  input  wire        arst_n_i,
  input  wire        ce_i,
  // request from the local side
  input  wire        req_valid_i,
  input  wire [1:0]  req_cmd_i,
  input  wire [12:0] req_addr_i,
  input  wire [7:0]  req_wdata_i,
  // supply monitor, high above the switch threshold
  input  wire        pwr_ok_i,
  // handshake and answer
  output wire        req_ready_o,
  output reg         rsp_valid_o,
  output reg  [7:0]  rsp_rdata_o,
  output reg         busy_o,
  // memory pins
  output reg  [12:0] mem_addr_o,
  output reg         mem_csel_n_o,
  output reg         mem_oen_n_o,
  output reg         mem_wstb_n_o,
  input  wire [7:0]  mem_data_i,
  output reg  [7:0]  mem_data_o,
  output reg         mem_data_oe_o
);

  localparam ST_IDLE  = 3'h0;
  localparam ST_SETUP = 3'h1;
  localparam ST_STRB  = 3'h2;
  localparam ST_HOLD  = 3'h3;
  localparam ST_WAIT  = 3'h4;

  // phase reload values, one less than the phase length
  localparam [23:0] SETUP_LD  = `NVSC_SETUP_CYC - 1;
  localparam [23:0] STROBE_LD = `NVSC_STROBE_CYC - 1;
  localparam [23:0] HOLD_LD   = `NVSC_HOLD_CYC - 1;
  localparam [23:0] CNT_ZERO  = 24'h000000;
  // index of the sixth and last read of a sequence
  localparam [2:0]  STEP_LAST = 3'h5;

  // state, phase counter, sequence step, command and supply history
  reg [2:0]  state_r;
  reg [2:0]  state_nxt;
  reg [23:0] cnt_r;
  reg [2:0]  step_r;
  reg [1:0]  cmd_r;
  reg        pwr_ok_d_r;

  // request taken, phase counter expired, more sequence reads to come
  wire       take_w     = req_valid_i && req_ready_o;
  wire       cnt_zero_w = (cnt_r == CNT_ZERO);
  wire       seq_more_w = cmd_r[1] && (step_r != STEP_LAST);

  // sequence address for a given step; last step depends on the command
  function [12:0] nvsc_seq_addr;
    input [2:0] step;
    input       restore;
    begin
      // steps 0 to 4 are fixed, step 5 picks save or restore
      case (step)
        3'h0:    nvsc_seq_addr = `NVSC_SEQ_A0;
        3'h1:    nvsc_seq_addr = `NVSC_SEQ_A1;
        3'h2:    nvsc_seq_addr = `NVSC_SEQ_A2;
        3'h3:    nvsc_seq_addr = `NVSC_SEQ_A3;
        3'h4:    nvsc_seq_addr = `NVSC_SEQ_A4;
        default: nvsc_seq_addr = restore ? `NVSC_SEQ_RESTORE
                                         : `NVSC_SEQ_SAVE; // [RQ13] [RQ14]
      endcase
    end
  endfunction

  // software saves are refused while the supply is low
  assign req_ready_o = (state_r == ST_IDLE) && !busy_o &&
                       !(req_cmd_i == `NVSC_CMD_SAVE && !pwr_ok_i); // [RQ21]

  // next state: setup, strobe and hold phases, then the wait of a sequence
  always @* begin
    state_nxt = state_r;
    case (state_r)
      // accept a request only when ready
      ST_IDLE:  if (take_w) state_nxt = ST_SETUP;
      ST_SETUP: if (cnt_zero_w) state_nxt = ST_STRB;
      ST_STRB:  if (cnt_zero_w) state_nxt = ST_HOLD;
      // sequence reads loop back until the sixth one is done
      ST_HOLD:  if (cnt_zero_w) begin
        if (seq_more_w)
          state_nxt = ST_SETUP;
        else if (cmd_r[1])
          state_nxt = ST_WAIT;
        else
          state_nxt = ST_IDLE;
      end
      // the device stays quiet for the save or restore duration
      ST_WAIT:  if (cnt_zero_w) state_nxt = ST_IDLE;
      default:  state_nxt = ST_IDLE;
    endcase
  end

  // sequencer and pin drivers
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_r       <= ST_IDLE;
      cnt_r         <= 24'h000000;
      step_r        <= 3'h0;
      cmd_r         <= 2'h0;
      pwr_ok_d_r    <= 1'b0;
      busy_o        <= 1'b1;
      rsp_valid_o   <= 1'b0;
      rsp_rdata_o   <= 8'h00;
      mem_addr_o    <= 13'h0000;
      mem_csel_n_o  <= 1'b1;
      mem_oen_n_o   <= 1'b1;
      mem_wstb_n_o  <= 1'b1;
      mem_data_o    <= 8'h00;
      mem_data_oe_o <= 1'b0;
    end else if (ce_i) begin
      state_r     <= state_nxt;
      // answer pulse lasts one cycle
      rsp_valid_o <= 1'b0;
      pwr_ok_d_r  <= pwr_ok_i;
      // phase counter runs down to zero
      if (cnt_r != 24'h000000)
        cnt_r <= cnt_r - 24'h000001;
      // supply return: set busy and load the power-up restore wait; strobe is not touched
      if (pwr_ok_i && !pwr_ok_d_r) begin
        busy_o <= 1'b1;
        cnt_r  <= PWRUP_CYC[23:0]; // [RQ11] [RQ12]
      end else if (!pwr_ok_i) begin
        busy_o <= 1'b1; // [RQ8] [RQ21]
      end else if (state_r == ST_IDLE && busy_o &&
                   cnt_r == 24'h000000) begin
        busy_o <= 1'b0;
      end
      case (state_r)
        // take the request and present the address
        ST_IDLE: if (take_w) begin
          cmd_r  <= req_cmd_i;
          step_r <= 3'h0; // [RQ22]
          cnt_r  <= SETUP_LD;
          // address set first, all strobes high, outputs enabled for writes
          mem_addr_o    <= req_cmd_i[1] ?
                           nvsc_seq_addr(3'h0, req_cmd_i[0])
                           : req_addr_i; // [RQ2] [RQ5]
          mem_data_o    <= req_wdata_i;
          mem_data_oe_o <= (req_cmd_i == `NVSC_CMD_WRITE);
          mem_oen_n_o   <= 1'b1; // [RQ6]
        end
        // select the device for the strobe phase
        ST_SETUP: if (cnt_zero_w) begin
          cnt_r        <= STROBE_LD;
          mem_csel_n_o <= 1'b0; // [RQ16]
          mem_wstb_n_o <= (cmd_r != `NVSC_CMD_WRITE); // [RQ4]
          mem_oen_n_o  <= (cmd_r != `NVSC_CMD_READ); // [RQ1]
        end
        // deselect, latching read data before the lines float
        ST_STRB: if (cnt_zero_w) begin
          cnt_r        <= HOLD_LD;
          mem_csel_n_o <= 1'b1; // [RQ4] write ends on rising edges
          mem_wstb_n_o <= 1'b1;
          mem_oen_n_o  <= 1'b1;
          if (cmd_r == `NVSC_CMD_READ)
            rsp_rdata_o <= mem_data_i; // [RQ3]
        end
        // release the data lines, then next step, wait or answer
        ST_HOLD: if (cnt_zero_w) begin
          mem_data_oe_o <= 1'b0;
          if (seq_more_w) begin
            // no other access intervenes between steps
            step_r     <= step_r + 3'h1; // [RQ15]
            cnt_r      <= SETUP_LD;
            mem_addr_o <= nvsc_seq_addr(step_r + 3'h1, cmd_r[0]);
          end else if (cmd_r[1]) begin
            step_r <= 3'h0; // [RQ22]
            cnt_r  <= cmd_r[0] ? RESTORE_CYC[23:0]
                               : SAVE_CYC[23:0]; // [RQ10] [RQ19] [RQ20]
          end else begin
            rsp_valid_o <= 1'b1;
          end
        end
        // save or restore time is over
        ST_WAIT: if (cnt_zero_w) begin
          rsp_valid_o <= 1'b1; // [RQ18] device quiet until here
        end
        default: ;
      endcase
    end
  end

endmodule
